//--- hw/trig_seq_consts.svh
/*
 * Register offsets, field positions, reset values and limits of the
 * triggered reading sequencer.
 * Assumes a 32-bit byte-addressed classic Wishbone slave port.
 */
`ifndef TRIG_SEQ_CONSTS_SVH
`define TRIG_SEQ_CONSTS_SVH
// register byte offsets
`define OFS_SETUP 8'h00
`define OFS_POLARITY 8'h04
`define OFS_CONFIG 8'h08
`define OFS_SETTLE 8'h0C
`define OFS_SAMPLES 8'h10
`define OFS_STATUS 8'h14
`define OFS_RESULT 8'h18
`define OFS_IRQ_STAT 8'h1C
`define OFS_IRQ_MASK 8'h20
`define OFS_REMAIN 8'h24
// setup register fields
`define SETUP_ARM_BIT 0
`define SETUP_EDGE_BIT 1
// config register fields
`define CFG_AUTORANGE_BIT 16
`define CFG_UNIT_BIT 17
// reset values
`define POLARITY_RESET 1'h0
`define UNIT_RESET 1'h0
`define CONFIG_RESET 16'h0000
// irq bits: result queued, sequence done, overrun, setup refused
`define IRQ_RESULT 0
`define IRQ_DONE 1
`define IRQ_OVERRUN 2
`define IRQ_REFUSED 3
`define IRQ_WIDTH 4
`endif

//--- hw/trig_seq_pkg.sv
/*
 * Types of the triggered reading sequencer.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package trig_seq_pkg;
   // measurement functions; codes 6 and 7 are functions not allowed here
   typedef enum logic [2:0] {
      fn_dc_volts, fn_ac_volts, fn_ohms, fn_ac_amps, fn_dc_amps, fn_rtd,
      fn_thermocouple, fn_other
   } func_type;
   // sequencer states
   typedef enum logic [1:0] {
      st_idle, st_wait_trig, st_start_read, st_wait_read
   } state_type;
   // measurement settings frozen while a sequence runs
   typedef struct packed {
      logic [3:0] interval;
      logic [3:0] aperture;
      logic [3:0] range;
      logic [0:0] spare;
      func_type func;
   } meas_cfg_type;
endpackage : trig_seq_pkg

//--- hw/triggered_reading_sequencer.sv
/*
 * Triggered reading sequencer: waits for the chosen external trigger
 * edge, takes settle_count+1 readings per edge, queues the last one in
 * a small FIFO for the host, and repeats for sample_count edges, one edge when sample_count is 0.
 * Assumes a measurement chain that answers each meas_start_o pulse with
 * one meas_done_i pulse, and a trigger input synchronous to core_clk_i.
 */
// Our own choices: the placing of the registers and the Wishbone slave port.
// Overview of operation
// - polarity 0 falling edge, 1 rising edge
// - polarity resets to falling edge
// - polarity governs every hardware trigger use
// - setup command waits for trigger edge
// - settle plus one readings, keep last
// - readings use settings frozen at arming
// - repeat sample_count triggers, one when sample_count is 0, then finish
// - autoranging off while sequence runs
// - full FIFO push flags overrun
// - only six measurement functions accepted
// - setup edge selector 1 rising, 0 falling
// - temperature unit celsius after reset
// - data available shown, one read per result
`timescale 1ns/1ns
`include "trig_seq_consts.svh"
module triggered_reading_sequencer
   import trig_seq_pkg::*;
#(
   parameter int DEPTH = 4,
   parameter int DATA_W = 32
)
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic reset_i,
   // classic wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // external trigger and measurement chain
   input wire logic ext_trigger_i,
   input wire logic meas_done_i,
   input wire logic [DATA_W-1:0] meas_data_i,
   output logic meas_start_o,
   output meas_cfg_type meas_cfg_o,
   output logic autorange_en_o,
   output logic hw_trigger_o,
   output logic unit_fahrenheit_o,
   // interrupt
   output logic irq_o
);
   localparam int CW = $clog2(DEPTH + 1);
   localparam int AW = $clog2(DEPTH);
   // depth must be a power of two so the index wraps by itself
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
   begin : g_bad_depth
      $error("DEPTH must be a power of two of at least 2");
   end
   state_type state;
   meas_cfg_type config_reg;
   logic trigger_polarity, temperature_unit_select, autorange_cfg;
   logic [7:0] settle_count, reads_left;
   logic [14:0] sample_count, samples_left;
   logic trig_prev, trig_edge, overrun, refused;
   logic [`IRQ_WIDTH-1:0] irq_stat, irq_mask, irq_event;
   logic [DATA_W-1:0] fifo_mem [DEPTH];
   logic [AW-1:0] wr_ptr, rd_ptr;
   logic [CW-1:0] fifo_count;
   logic fifo_full, fifo_empty, push, pop, last_read;
   logic bus_req, bus_wr, bus_rd, arm_cmd, func_ok;
   // one access per request; ack is dropped in the cycle after it rose
   assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];
   assign bus_rd = bus_req && !wb_we_i;
   assign arm_cmd = bus_wr && wb_adr_i == `OFS_SETUP
      && wb_dat_i[`SETUP_ARM_BIT];
   assign func_ok = config_reg.func inside {fn_dc_volts, fn_ac_volts,
      fn_ohms, fn_ac_amps, fn_dc_amps, fn_rtd};
   // trigger edge seen on the selected polarity
   assign trig_edge = trigger_polarity ? (ext_trigger_i && !trig_prev)
      : (!ext_trigger_i && trig_prev);
   assign hw_trigger_o = trig_edge;
   assign last_read = state == st_wait_read && meas_done_i
      && reads_left == 8'h00;
   assign push = last_read;
   assign pop = bus_rd && wb_adr_i == `OFS_RESULT && !fifo_empty;
   assign fifo_full = fifo_count == CW'(DEPTH);
   assign fifo_empty = fifo_count == '0;
   assign meas_start_o = state == st_start_read;
   assign autorange_en_o = autorange_cfg && state == st_idle;
   assign unit_fahrenheit_o = temperature_unit_select;
   assign irq_o = |(irq_stat & irq_mask);
   // previous trigger level for edge detection
   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
         trig_prev <= 1'b0;
      else
         trig_prev <= ext_trigger_i;
   end
   // setup registers; arming also loads polarity from the edge selector
   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         trigger_polarity <= `POLARITY_RESET;
         temperature_unit_select <= `UNIT_RESET;
         autorange_cfg <= 1'b0;
         config_reg <= `CONFIG_RESET;
         settle_count <= 8'h00;
         sample_count <= 15'h0001;
         irq_mask <= '0;
      end
      else if (bus_wr)
      begin
         unique case (wb_adr_i)
            `OFS_SETUP:
               if (wb_dat_i[`SETUP_ARM_BIT] && state == st_idle)
                  trigger_polarity <= wb_dat_i[`SETUP_EDGE_BIT];
            `OFS_POLARITY: trigger_polarity <= wb_dat_i[0];
            `OFS_CONFIG:
            begin
               config_reg <= meas_cfg_type'(wb_dat_i[15:0]);
               autorange_cfg <= wb_dat_i[`CFG_AUTORANGE_BIT];
               temperature_unit_select <= wb_dat_i[`CFG_UNIT_BIT];
            end
            `OFS_SETTLE: settle_count <= wb_dat_i[7:0];
            `OFS_SAMPLES: sample_count <= wb_dat_i[14:0];
            `OFS_IRQ_MASK: irq_mask <= wb_dat_i[`IRQ_WIDTH-1:0];
            default: ;
         endcase
      end
   end
   // sequencer; arming is ignored while a sequence runs
   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         state <= st_idle;
         reads_left <= 8'h00;
         samples_left <= 15'h0000;
         meas_cfg_o <= `CONFIG_RESET;
      end
      else
      begin
         unique case (state)
            st_idle:
               if (arm_cmd && func_ok)
               begin
                  state <= st_wait_trig;
                  samples_left <= sample_count;
                  meas_cfg_o <= config_reg;
               end
            st_wait_trig:
               if (trig_edge)
               begin
                  reads_left <= settle_count;
                  state <= st_start_read;
               end
            st_start_read: state <= st_wait_read;
            st_wait_read:
               if (meas_done_i)
               begin
                  if (reads_left != 8'h00)
                  begin
                     reads_left <= reads_left - 8'h01;
                     state <= st_start_read;
                  end
                  else
                  begin
                     samples_left <= samples_left - 15'h0001;
                     state <= samples_left <= 15'h0001 ? st_idle
                        : st_wait_trig;
                  end
               end
         endcase
      end
   end
   // fifo storage, one slot per entry
   for (genvar i = 0; i < DEPTH; i++)
   begin : g_slot
      always_ff @(posedge core_clk_i)
      begin
         if (reset_i)
            fifo_mem[i] <= '0;
         else if (push && !fifo_full && wr_ptr == AW'(i))
            fifo_mem[i] <= meas_data_i;
      end
   end
   // fifo pointers; a push into a full fifo is dropped
   always_ff @(posedge core_clk_i)
   begin
      if (reset_i || (arm_cmd && state == st_idle))
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         fifo_count <= '0;
      end
      else
      begin
         if (push && !fifo_full)
            wr_ptr <= wr_ptr + AW'(1);
         if (pop)
            rd_ptr <= rd_ptr + AW'(1);
         fifo_count <= fifo_count + CW'(push && !fifo_full) - CW'(pop);
      end
   end
   // overrun stays until the next arming; refused tracks the last arm
   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         overrun <= 1'b0;
         refused <= 1'b0;
      end
      else if (arm_cmd && state == st_idle)
      begin
         overrun <= 1'b0;
         refused <= !func_ok;
      end
      else if (push && fifo_full)
         overrun <= 1'b1;
   end
   // sticky interrupt status; a new event wins over a write-one clear
   assign irq_event[`IRQ_RESULT] = push && !fifo_full;
   assign irq_event[`IRQ_DONE] = last_read && samples_left <= 15'h0001;
   assign irq_event[`IRQ_OVERRUN] = push && fifo_full;
   assign irq_event[`IRQ_REFUSED] = arm_cmd && state == st_idle && !func_ok;
   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
         irq_stat <= '0;
      else if (bus_wr && wb_adr_i == `OFS_IRQ_STAT)
         irq_stat <= (irq_stat & ~wb_dat_i[`IRQ_WIDTH-1:0]) | irq_event;
      else
         irq_stat <= irq_stat | irq_event;
   end
   // bus answer one cycle after the request; unmapped reads give zero
   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_o <= bus_req;
         wb_dat_o <= 32'h0000_0000;
         if (bus_rd)
         begin
            unique case (wb_adr_i)
               `OFS_POLARITY: wb_dat_o <= {31'h0, trigger_polarity};
               `OFS_CONFIG:
                  wb_dat_o <= {14'h0, temperature_unit_select,
                     autorange_cfg, config_reg};
               `OFS_SETTLE: wb_dat_o <= {24'h0, settle_count};
               `OFS_SAMPLES: wb_dat_o <= {17'h0, sample_count};
               `OFS_STATUS:
                  wb_dat_o <= {16'h0, 8'(fifo_count), 4'h0, refused,
                     overrun, !fifo_empty, state != st_idle};
               `OFS_RESULT: wb_dat_o <= 32'(fifo_mem[rd_ptr]);
               `OFS_IRQ_STAT: wb_dat_o <= {28'h0, irq_stat};
               `OFS_IRQ_MASK: wb_dat_o <= {28'h0, irq_mask};
               `OFS_REMAIN: wb_dat_o <= {17'h0, samples_left};
               default: wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (reset_i);
   property p_arm_waits;
      arm_cmd && state == st_idle && func_ok |=> state == st_wait_trig
         ##0 !meas_start_o;
   endproperty
   a_arm_waits: assert property (p_arm_waits)
      else $error("arming did not enter the wait state");
   property p_no_read_without_edge;
      state == st_wait_trig && !trig_edge |=> !meas_start_o;
   endproperty
   a_no_read_without_edge: assert property (p_no_read_without_edge)
      else $error("reading started without a trigger edge");
   property p_edge_polarity;
      trig_edge |-> ext_trigger_i == trigger_polarity
         && $past(ext_trigger_i) != trigger_polarity;
   endproperty
   a_edge_polarity: assert property (p_edge_polarity)
      else $error("trigger edge taken on the wrong polarity");
   property p_polarity_reset;
      $past(reset_i) |-> !trigger_polarity && !unit_fahrenheit_o;
   endproperty
   a_polarity_reset: assert property (p_polarity_reset)
      else $error("polarity or unit not at reset value");
   property p_autorange_off;
      state != st_idle |-> !autorange_en_o;
   endproperty
   a_autorange_off: assert property (p_autorange_off)
      else $error("autoranging active during a sequence");
   property p_push_last_only;
      state == st_wait_read && meas_done_i && reads_left != 8'h00
         |=> fifo_count <= $past(fifo_count);
   endproperty
   a_push_last_only: assert property (p_push_last_only)
      else $error("settling reading was queued");
   property p_overrun;
      push && fifo_full && !pop |=> overrun && irq_stat[`IRQ_OVERRUN];
   endproperty
   a_overrun: assert property (p_overrun)
      else $error("overrun not flagged on full fifo");
   property p_finish;
      last_read && samples_left == 15'h0001 |=> state == st_idle;
   endproperty
   a_finish: assert property (p_finish)
      else $error("sequence did not finish after last sample");
   property p_refuse;
      arm_cmd && state == st_idle && !func_ok |=> state == st_idle && refused;
   endproperty
   a_refuse: assert property (p_refuse)
      else $error("disallowed function was armed");
   property p_cfg_frozen;
      state != st_idle && $past(state) != st_idle |-> $stable(meas_cfg_o);
   endproperty
   a_cfg_frozen: assert property (p_cfg_frozen)
      else $error("measurement settings changed during a sequence");
endmodule : triggered_reading_sequencer

//--- verif/meas_chain_model.sv
/*
 * Behavioural measurement chain that stands beside the sequencer.
 * Assumes one start pulse per reading and a single clock domain.
 */
`timescale 1ns/1ns
module meas_chain_model
#(
   parameter int FAST = 1,
   parameter int SLOW = 5
)
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic reset_i,
   // request side
   input wire logic start_i,
   input wire logic slow_i,
   // answer side
   output logic done_o,
   output logic [31:0] data_o,
   output logic [31:0] count_o
);
   logic busy;
   logic [7:0] wait_cnt;

   // each reading carries its own running index so the bench can tell
   // which one was kept; outside done the data toggles to expose misuse
   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         busy <= 1'b0;
         wait_cnt <= 8'h00;
         done_o <= 1'b0;
         count_o <= 32'h0;
         data_o <= 32'hFFFFFFFF;
      end
      else if (busy && wait_cnt == 8'h00)
      begin
         busy <= 1'b0;
         done_o <= 1'b1;
         count_o <= count_o + 32'h1;
         data_o <= count_o + 32'h1;
      end
      else
      begin
         done_o <= 1'b0;
         data_o <= ~data_o;
         if (start_i)
         begin
            busy <= 1'b1;
            wait_cnt <= slow_i ? 8'(SLOW - 1) : 8'(FAST - 1);
         end
         else if (busy)
            wait_cnt <= wait_cnt - 8'h01;
      end
   end
endmodule : meas_chain_model

//--- verif/triggered_reading_sequencer_test.sv
/*
 * Self-checking bench for the triggered reading sequencer.
 * Assumes the register map of the design and a bus answer in under 50 cycles.
 */
`timescale 1ns/1ns
`include "trig_seq_consts.svh"
module triggered_reading_sequencer_test;
   import trig_seq_pkg::*;
   logic core_clk_i;
   logic reset_i;
   logic wb_cyc_i, wb_stb_i, wb_we_i;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, meas_data, n_reads, q;
   logic wb_ack_o, ext_trigger_i, meas_done, meas_start, slow;
   logic autorange_en_o, hw_trigger_o, unit_fahrenheit_o, irq_o;
   meas_cfg_type meas_cfg_o;
   int n_fail = 0;
   int compares = 0;
   int n_hw = 0;
   int exp_rd = 0;

   triggered_reading_sequencer #(.DEPTH(4), .DATA_W(32)) uut (
      .core_clk_i(core_clk_i), .reset_i(reset_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .ext_trigger_i(ext_trigger_i),
      .meas_done_i(meas_done), .meas_data_i(meas_data),
      .meas_start_o(meas_start), .meas_cfg_o(meas_cfg_o),
      .autorange_en_o(autorange_en_o), .hw_trigger_o(hw_trigger_o),
      .unit_fahrenheit_o(unit_fahrenheit_o), .irq_o(irq_o));

   meas_chain_model chain (
      .core_clk_i(core_clk_i), .reset_i(reset_i), .start_i(meas_start),
      .slow_i(slow), .done_o(meas_done), .data_o(meas_data),
      .count_o(n_reads));

   // free-running clock, 10 ns period
   initial
   begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end

   // pulses of the edge indication, counted at the sampling edge
   always @(posedge core_clk_i)
      if (hw_trigger_o === 1'b1)
         n_hw++;

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // one classic cycle; held until ack is sampled, no latency assumed
   task automatic xfer(input logic we, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge core_clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do
      begin
         @(posedge core_clk_i);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 50);
      r = wb_dat_o;
      if (n >= 50)
         chk("bus ack", 32'h1, 32'h0);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      xfer(1'b1, a, d, r);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      xfer(1'b0, a, 32'h0, r);
   endtask : rd

   // trigger source: move the line, then let the sequencer see it
   task automatic lvl(input logic v);
      @(posedge core_clk_i);
      ext_trigger_i <= v;
      repeat (4) @(posedge core_clk_i);
   endtask : lvl

   // poll the fifo count, as a host would, under a bounded count
   task automatic wait_fifo(input logic [7:0] n);
      logic [31:0] s;
      int i;
      for (i = 0; i < 40; i++)
      begin
         rd(`OFS_STATUS, s);
         if (s[15:8] === n)
            break;
      end
      chk("fifo count", {24'h0, n}, {24'h0, s[15:8]});
   endtask : wait_fifo

   // one rise then one fall, one qualifying edge for either polarity, then take the single kept reading
   task automatic one_trigger(input int settle);
      lvl(1'b1);
      lvl(1'b0);
      exp_rd += settle + 1;
      wait_fifo(8'h01);
      rd(`OFS_RESULT, q);
      chk("result", 32'(exp_rd), q);
   endtask : one_trigger

   task complete_run;
      $display("comparisons %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : complete_run

   // watchdog: the tests need well under 20000 cycles
   initial
   begin
      #200000;
      n_fail++;
      complete_run;
   end

   initial
   begin
      {wb_cyc_i, wb_stb_i, wb_we_i, ext_trigger_i, slow} = 5'h00;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'hF;
      wb_dat_i = 32'h0;
      reset_i = 1'b1;
      repeat (6) @(posedge core_clk_i);
      reset_i <= 1'b0;
      // reset values, unmapped place, temperature unit
      rd(`OFS_POLARITY, q);
      chk("polarity", 32'h0, q);
      rd(`OFS_SAMPLES, q);
      chk("samples", 32'h1, q);
      rd(8'h3C, q);
      chk("unmapped", 32'h0, q);
      chk("unit", 32'h0, {31'h0, unit_fahrenheit_o});
      wr(`OFS_CONFIG, 32'h00020000);
      chk("unit", 32'h1, {31'h0, unit_fahrenheit_o});
      $display("test reset done");
      // edge selection on the hardware trigger indication
      lvl(1'b1);
      chk("rise ignored", 32'h0, 32'(n_hw));
      lvl(1'b0);
      chk("fall seen", 32'h1, 32'(n_hw));
      wr(`OFS_POLARITY, 32'h1);
      lvl(1'b1);
      lvl(1'b0);
      chk("rise seen", 32'h2, 32'(n_hw));
      $display("test polarity done");
      // two triggers, two settling readings each, frozen settings
      wr(`OFS_CONFIG, 32'h00013251);
      chk("autorange idle", 32'h1, {31'h0, autorange_en_o});
      wr(`OFS_SETTLE, 32'h2);
      wr(`OFS_SAMPLES, 32'h2);
      wr(`OFS_IRQ_MASK, 32'h3);
      wr(`OFS_SETUP, 32'h1);
      wr(`OFS_CONFIG, 32'h00010000);
      chk("autorange run", 32'h0, {31'h0, autorange_en_o});
      chk("frozen cfg", 32'h3251, 32'(meas_cfg_o));
      chk("no early read", 32'h0, n_reads);
      rd(`OFS_REMAIN, q);
      chk("remain", 32'h2, q);
      one_trigger(2);
      rd(`OFS_REMAIN, q);
      chk("remain", 32'h1, q);
      one_trigger(2);
      rd(`OFS_STATUS, q);
      chk("finished", 32'h0, q);
      chk("reading count", 32'h6, n_reads);
      rd(`OFS_IRQ_STAT, q);
      chk("irq status", 32'h3, q);
      chk("irq on", 32'h1, {31'h0, irq_o});
      wr(`OFS_IRQ_MASK, 32'h0);
      chk("irq masked", 32'h0, {31'h0, irq_o});
      wr(`OFS_IRQ_STAT, 32'h3);
      rd(`OFS_IRQ_STAT, q);
      chk("irq cleared", 32'h0, q);
      $display("test sequence done");
      // rising edge chosen at arming
      wr(`OFS_SETTLE, 32'h0);
      wr(`OFS_SAMPLES, 32'h1);
      wr(`OFS_SETUP, 32'h3);
      rd(`OFS_POLARITY, q);
      chk("edge select", 32'h1, q);
      lvl(1'b1);
      exp_rd += 1;
      wait_fifo(8'h01);
      rd(`OFS_RESULT, q);
      chk("rise result", 32'(exp_rd), q);
      lvl(1'b0);
      $display("test rising done");
      // every function code: six accepted, two refused
      for (int f = 0; f < 8; f++)
      begin
         wr(`OFS_CONFIG, 32'(f));
         wr(`OFS_SETUP, 32'h1);
         rd(`OFS_STATUS, q);
         chk("accept", (f < 6) ? 32'h1 : 32'h8, q & 32'h9);
         if (f < 6)
            one_trigger(0);
      end
      $display("test functions done");
      // slow chain, host stalls: fifo of four overruns
      slow <= 1'b1;
      wr(`OFS_CONFIG, 32'h0);
      wr(`OFS_SAMPLES, 32'h6);
      wr(`OFS_SETUP, 32'h1);
      repeat (6)
      begin
         lvl(1'b1);
         lvl(1'b0);
         repeat (8) @(posedge core_clk_i);
      end
      rd(`OFS_STATUS, q);
      chk("overrun", 32'h00000406, q);
      rd(`OFS_IRQ_STAT, q);
      chk("irq events", 32'hF, q);
      for (int i = 1; i <= 4; i++)
      begin
         rd(`OFS_RESULT, q);
         chk("kept", 32'(exp_rd + i), q);
      end
      exp_rd += 6;
      rd(`OFS_STATUS, q);
      chk("overrun sticky", 32'h4, q);
      wr(`OFS_SAMPLES, 32'h1);
      wr(`OFS_SETUP, 32'h1);
      rd(`OFS_STATUS, q);
      chk("rearm clears", 32'h1, q);
      one_trigger(0);
      $display("test overrun done");
      complete_run;
   end
endmodule : triggered_reading_sequencer_test
